// File: write_guard.v
// Physical memory write guard with APB register access.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module write_guard (
   // Clock and reset
   input  wire        I_CLK,
   input  wire        I_RST_B,
   // APB slave
   input  wire        I_PSEL,
   input  wire        I_PENABLE,
   input  wire        I_PWRITE,
   input  wire [15:0] I_PADDR,
   input  wire [31:0] I_PWDATA,
   output wire        I_PREADY_UNUSED_DUMMY_NEVER,
   output wire        O_PREADY,
   output reg  [31:0] O_PRDATA,
   output wire        O_PSLVERR,
   // Processor write cycle
   input  wire        I_WR_REQ,
   input  wire [19:0] I_WR_ADDR,
   input  wire        I_USER_MODE,
   output wire        O_WR_ALLOW,
   // Violation interrupt request
   input  wire        I_IRQ_ACK,
   output wire        O_IRQ_REQ,
   output wire [1:0]  O_IRQ_PRIORITY,
   output wire [19:0] O_VIOL_ADDR
);
`include "wguard_defs.vh"

   // ****************************************************************
   // Register bus decode
   // ****************************************************************
   wire [11:0] idx      = I_PADDR[13:2];
   wire        acc      = I_PSEL && I_PENABLE;
   wire        wr       = acc && I_PWRITE;
   wire        aligned  = (I_PADDR[1:0] == 2'b00) && (I_PADDR[15:14] == 2'b00);
   reg         mapped;

   always @* begin
      case (idx)
         `IDX_PROTECT_CONTROL, `IDX_DUAL_MODE_ENABLE, `IDX_BLOCK_PROTECT_LOW,
         `IDX_BLOCK_PROTECT_HIGH, `IDX_SEGMENT_A_SELECT, `IDX_SEGMENT_A_SUB_LOW,
         `IDX_SEGMENT_A_SUB_HIGH, `IDX_SEGMENT_B_SELECT, `IDX_SEGMENT_B_SUB_LOW,
         `IDX_SEGMENT_B_SUB_HIGH, `IDX_VIOLATION_STATUS: mapped = aligned;
         default: mapped = 1'b0;
      endcase
   end

   wire wr_ok = wr && mapped;

   assign I_PREADY_UNUSED_DUMMY_NEVER = 1'b0;
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = acc && !mapped;

   // ****************************************************************
   // Control registers
   // ****************************************************************
   reg        all_modes_ff;
   reg        dual_mode_ff;
   reg [15:0] block_protect_ff;
   reg        irq_ff;
   reg [19:0] viol_addr_ff;
   reg [7:0]  viol_count_ff;

   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         all_modes_ff     <= 1'b0;
         dual_mode_ff     <= 1'b0;
         block_protect_ff <= 16'h0000;
      end else if (wr_ok) begin
         case (idx)
            // Reserved bits 7:1 are left to software to keep at zero.
            `IDX_PROTECT_CONTROL:    all_modes_ff <= I_PWDATA[`CTRL_ALL_MODES_BIT];
            `IDX_DUAL_MODE_ENABLE:   dual_mode_ff <= I_PWDATA[`DUAL_ENABLE_BIT];
            `IDX_BLOCK_PROTECT_LOW:  block_protect_ff[7:0]  <= I_PWDATA[7:0];
            `IDX_BLOCK_PROTECT_HIGH: block_protect_ff[15:8] <= I_PWDATA[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Sub-block segments
   // ****************************************************************
   wire        hit_a;
   wire        hit_b;
   wire [31:0] regs_a;
   wire [31:0] regs_b;

   segment_guard u_seg_a (
      .i_clk       (I_CLK),
      .i_rst_b     (I_RST_B),
      .i_wr_select (wr_ok && idx == `IDX_SEGMENT_A_SELECT),
      .i_wr_low    (wr_ok && idx == `IDX_SEGMENT_A_SUB_LOW),
      .i_wr_high   (wr_ok && idx == `IDX_SEGMENT_A_SUB_HIGH),
      .i_wdata     (I_PWDATA[7:0]),
      .i_addr      (I_WR_ADDR),
      .o_hit       (hit_a),
      .o_regs      (regs_a)
   );

   segment_guard u_seg_b (
      .i_clk       (I_CLK),
      .i_rst_b     (I_RST_B),
      .i_wr_select (wr_ok && idx == `IDX_SEGMENT_B_SELECT),
      .i_wr_low    (wr_ok && idx == `IDX_SEGMENT_B_SUB_LOW),
      .i_wr_high   (wr_ok && idx == `IDX_SEGMENT_B_SUB_HIGH),
      .i_wdata     (I_PWDATA[7:0]),
      .i_addr      (I_WR_ADDR),
      .o_hit       (hit_b),
      .o_regs      (regs_b)
   );

   // ****************************************************************
   // Protection check
   // ****************************************************************
   // User mode only exists once dual mode is enabled.
   wire in_user   = dual_mode_ff && I_USER_MODE;
   wire enforce   = all_modes_ff || in_user;
   wire prot_hit  = block_protect_ff[I_WR_ADDR[19:16]] || hit_a || hit_b;
   wire blocked   = I_WR_REQ && enforce && prot_hit;

   assign O_WR_ALLOW = I_WR_REQ && !blocked;

   // ****************************************************************
   // Violation request
   // ****************************************************************
   // A new violation wins over an acknowledge in the same cycle.
   always @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         irq_ff        <= 1'b0;
         viol_addr_ff  <= 20'h0_0000;
         viol_count_ff <= 8'h00;
      end else begin
         if (blocked) begin
            irq_ff        <= 1'b1;
            viol_addr_ff  <= I_WR_ADDR;
            viol_count_ff <= (viol_count_ff == 8'hFF) ? viol_count_ff : viol_count_ff + 8'h01;
         end else if (I_IRQ_ACK) begin
            irq_ff <= 1'b0;
         end
      end
   end

   assign O_IRQ_REQ      = irq_ff;
   assign O_IRQ_PRIORITY = `PRIORITY_LEVEL;
   assign O_VIOL_ADDR    = viol_addr_ff;

   // ****************************************************************
   // Read data
   // ****************************************************************
   always @* begin
      case (idx)
         `IDX_PROTECT_CONTROL:    O_PRDATA = {31'h0000_0000, all_modes_ff};
         `IDX_DUAL_MODE_ENABLE:   O_PRDATA = {31'h0000_0000, dual_mode_ff};
         `IDX_BLOCK_PROTECT_LOW:  O_PRDATA = {24'h00_0000, block_protect_ff[7:0]};
         `IDX_BLOCK_PROTECT_HIGH: O_PRDATA = {24'h00_0000, block_protect_ff[15:8]};
         `IDX_SEGMENT_A_SELECT:   O_PRDATA = {28'h000_0000, regs_a[27:24]};
         `IDX_SEGMENT_A_SUB_LOW:  O_PRDATA = {24'h00_0000, regs_a[15:8]};
         `IDX_SEGMENT_A_SUB_HIGH: O_PRDATA = {24'h00_0000, regs_a[23:16]};
         `IDX_SEGMENT_B_SELECT:   O_PRDATA = {28'h000_0000, regs_b[27:24]};
         `IDX_SEGMENT_B_SUB_LOW:  O_PRDATA = {24'h00_0000, regs_b[15:8]};
         `IDX_SEGMENT_B_SUB_HIGH: O_PRDATA = {24'h00_0000, regs_b[23:16]};
         `IDX_VIOLATION_STATUS:   O_PRDATA = {3'h0, irq_ff, viol_count_ff, viol_addr_ff};
         default:                 O_PRDATA = 32'h0000_0000;
      endcase
      if (!(acc && !I_PWRITE && mapped)) begin
         O_PRDATA = 32'h0000_0000;
      end
   end

endmodule

// File: wguard_defs.vh
// Constants and register map of the physical memory write guard.
// ****************************************************************
// ****************************************************************
`ifndef WGUARD_DEFS_VH
`define WGUARD_DEFS_VH

// Register indices; byte address is four times the index.
`define IDX_PROTECT_CONTROL     12'h0440
`define IDX_DUAL_MODE_ENABLE    12'h0420
`define IDX_BLOCK_PROTECT_LOW   12'h0460
`define IDX_BLOCK_PROTECT_HIGH  12'h0461
`define IDX_SEGMENT_A_SELECT    12'h0480
`define IDX_SEGMENT_A_SUB_LOW   12'h0481
`define IDX_SEGMENT_A_SUB_HIGH  12'h0482
`define IDX_SEGMENT_B_SELECT    12'h0484
`define IDX_SEGMENT_B_SUB_LOW   12'h0485
`define IDX_SEGMENT_B_SUB_HIGH  12'h0486
`define IDX_VIOLATION_STATUS    12'h04F0

// Field positions.
`define CTRL_ALL_MODES_BIT      0
`define DUAL_ENABLE_BIT         0
`define SEG_SELECT_MSB          3
`define PRIORITY_LEVEL          2'h3

// Reset values.
`define RESET_REG8              8'h00

`endif

// File: segment_guard.v
// One 64 KB protection segment of sixteen 4 KB sub-blocks with its select and mask registers.
`timescale 1ns/1ps
module segment_guard (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_rst_b,
   // Register writes
   input  wire        i_wr_select,
   input  wire        i_wr_low,
   input  wire        i_wr_high,
   input  wire [7:0]  i_wdata,
   // Address check
   input  wire [19:0] i_addr,
   output wire        o_hit,
   output wire [31:0] o_regs
);
`include "wguard_defs.vh"

   reg  [3:0] select_ff;
   reg  [7:0] sub_low_ff;
   reg  [7:0] sub_high_ff;
   wire [15:0] sub_mask;

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         select_ff   <= 4'h0;
         sub_low_ff  <= `RESET_REG8;
         sub_high_ff <= `RESET_REG8;
      end else begin
         if (i_wr_select) begin
            select_ff <= i_wdata[`SEG_SELECT_MSB:0];
         end
         if (i_wr_low) begin
            sub_low_ff <= i_wdata;
         end
         if (i_wr_high) begin
            sub_high_ff <= i_wdata;
         end
      end
   end

   assign sub_mask = {sub_high_ff, sub_low_ff};
   assign o_hit    = (select_ff == i_addr[19:16]) && sub_mask[i_addr[15:12]];
   assign o_regs   = {4'h0, select_ff, sub_high_ff, sub_low_ff, 8'h00};

endmodule

// File: write_guard_props.sv
// Concurrent checks of the write guard at its top-level ports.
`timescale 1ns/1ps
module write_guard_props (
   // Clock and reset
   input wire        I_CLK,
   input wire        I_RST_B,
   // Write cycle and request
   input wire        I_WR_REQ,
   input wire [19:0] I_WR_ADDR,
   input wire        O_WR_ALLOW,
   input wire        I_IRQ_ACK,
   input wire        O_IRQ_REQ,
   input wire [1:0]  O_IRQ_PRIORITY,
   input wire [19:0] O_VIOL_ADDR
);
   wire blk = I_WR_REQ && !O_WR_ALLOW;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   a_idle_no_allow: assert property (!I_WR_REQ |-> !O_WR_ALLOW)
      else $error("allow without request");
   a_block_raises: assert property (blk |=> O_IRQ_REQ && O_VIOL_ADDR == $past(I_WR_ADDR))
      else $error("blocked write not flagged");
   a_prio_three: assert property (O_IRQ_PRIORITY == 2'h3)
      else $error("priority not three");
   a_irq_sticky: assert property (O_IRQ_REQ && !I_IRQ_ACK |=> O_IRQ_REQ)
      else $error("request dropped early");
   a_irq_clear: assert property (O_IRQ_REQ && I_IRQ_ACK && !blk |=> !O_IRQ_REQ)
      else $error("request not cleared");
   a_new_block_wins: assert property (I_IRQ_ACK && blk |=> O_IRQ_REQ)
      else $error("new block lost");
   a_no_cause: assert property (!O_IRQ_REQ && !blk |=> !O_IRQ_REQ)
      else $error("request without cause");
   a_addr_held: assert property (!blk |=> $stable(O_VIOL_ADDR))
      else $error("address moved");
endmodule
bind write_guard write_guard_props write_guard_props_inst (.*);

// File: cpu_write_model.sv
// Processor core model issuing physical memory write cycles.
`timescale 1ns/1ps
module cpu_write_model (
   // Clock
   input  wire        i_clk,
   // Write cycle
   input  wire        i_allow,
   output reg         o_wr_req,
   output reg  [19:0] o_wr_addr,
   output reg         o_user_mode
);
   initial begin
      o_wr_req = 1'b0;
      o_wr_addr = 20'h0_0000;
      o_user_mode = 1'b0;
   end
   // A released address bus shows the inverse so stale values cannot match.
   task automatic write_cycle(input [19:0] addr, input user, output ok);
      @(posedge i_clk);
      o_wr_req <= 1'b1;
      o_wr_addr <= addr;
      o_user_mode <= user;
      @(negedge i_clk);
      ok = i_allow;
      @(posedge i_clk);
      o_wr_req <= 1'b0;
      o_wr_addr <= ~addr;
   endtask
endmodule

// File: write_guard_bench.sv
// Self-checking bench for the write guard.
`timescale 1ns/1ps
module write_guard_bench;
   reg         clk, rst_b, psel, penable, pwrite, irq_ack, err;
   reg  [15:0] paddr;
   reg  [31:0] pwdata, rd;
   wire        pready, pslverr, wr_req, user_mode, wr_allow, irq_req;
   wire [31:0] prdata;
   wire [19:0] wr_addr, viol_addr;
   wire [1:0]  irq_prio;
   integer     error_cnt, cmp_count;
   write_guard write_guard_inst (.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PREADY_UNUSED_DUMMY_NEVER(), .O_PREADY(pready),
      .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_WR_REQ(wr_req), .I_WR_ADDR(wr_addr), .I_USER_MODE(user_mode),
      .O_WR_ALLOW(wr_allow), .I_IRQ_ACK(irq_ack), .O_IRQ_REQ(irq_req), .O_IRQ_PRIORITY(irq_prio),
      .O_VIOL_ADDR(viol_addr));
   cpu_write_model cpu_write_model_inst (.i_clk(clk), .i_allow(wr_allow), .o_wr_req(wr_req),
      .o_wr_addr(wr_addr), .o_user_mode(user_mode));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input [31:0] got, input [31:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input [15:0] a, input w, input [31:0] d);
      integer n;
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH at %0t: bus timeout", $time);
         close_out;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic try(input [19:0] a, input u, input exp_ok);
      reg ok;
      cpu_write_model_inst.write_cycle(a, u, ok);
      chk(ok, exp_ok);
      @(negedge clk);
      chk(irq_prio, 2'h3);
      chk(irq_req, !exp_ok);
      if (!exp_ok) chk(viol_addr, a);
      @(posedge clk);
      irq_ack <= 1'b1;
      @(posedge clk);
      irq_ack <= 1'b0;
      @(negedge clk);
      chk(irq_req, 1'b0);
   endtask
   task automatic t_reset;
      apb(16'h1100, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(16'h1110, 1'b0, 32'h0000_0000);
      chk(err, 1'b1);
      try(20'h0_0000, 1'b0, 1'b1);
      $display("reset test done");
   endtask
   task automatic t_blocks;
      apb(16'h1100, 1'b1, 32'h0000_0001);
      apb(16'h1180, 1'b1, 32'h0000_0081);
      apb(16'h1184, 1'b1, 32'h0000_0001);
      apb(16'h1180, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0081);
      apb(16'h1184, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      try(20'h0_FFFF, 1'b0, 1'b0);
      try(20'h1_0000, 1'b0, 1'b1);
      try(20'h7_0000, 1'b1, 1'b0);
      try(20'h6_FFFF, 1'b1, 1'b1);
      try(20'h8_0000, 1'b0, 1'b0);
      try(20'hF_FFFF, 1'b0, 1'b1);
      $display("block test done");
   endtask
   task automatic t_modes;
      apb(16'h1100, 1'b1, 32'h0000_0000);
      try(20'h0_1234, 1'b1, 1'b1);
      apb(16'h1080, 1'b1, 32'h0000_0001);
      try(20'h0_1234, 1'b1, 1'b0);
      try(20'h0_1234, 1'b0, 1'b1);
      $display("mode test done");
   endtask
   task automatic t_segments;
      apb(16'h1180, 1'b1, 32'h0000_0000);
      apb(16'h1184, 1'b1, 32'h0000_0000);
      apb(16'h1100, 1'b1, 32'h0000_0001);
      apb(16'h1200, 1'b1, 32'h0000_0003);
      apb(16'h1204, 1'b1, 32'h0000_0001);
      apb(16'h1208, 1'b1, 32'h0000_0080);
      apb(16'h1210, 1'b1, 32'h0000_0005);
      apb(16'h1214, 1'b1, 32'h0000_0002);
      apb(16'h1200, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      apb(16'h1208, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0080);
      try(20'h3_0FFF, 1'b0, 1'b0);
      try(20'h3_1000, 1'b0, 1'b1);
      try(20'h3_F000, 1'b0, 1'b0);
      try(20'h3_E000, 1'b0, 1'b1);
      try(20'h4_0000, 1'b0, 1'b1);
      try(20'h5_1000, 1'b0, 1'b0);
      apb(16'h13C0, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0075_1000);
      $display("segment test done");
   endtask
   initial begin
      rst_b = 1'b0;
      {psel, penable, pwrite, irq_ack} = 4'h0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      error_cnt = 0;
      cmp_count = 0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_blocks;
      t_modes;
      t_segments;
      close_out;
   end
endmodule
